/* File: src/ssc_pkg.sv */
// constants, state codes and carrier types of the serial slave control registers
// assumes one 200 MHz clock domain; pins are synchronised before use
`default_nettype none
package ssc_pkg;

    // register offsets
    localparam logic [7:0] OFF_STATUS   = 8'h00;
    localparam logic [7:0] OFF_PDN      = 8'h01;
    localparam logic [7:0] OFF_OVR      = 8'h02;
    localparam logic [7:0] OFF_SP3      = 8'h03;
    localparam logic [7:0] OFF_SP4      = 8'h04;
    localparam logic [7:0] OFF_SP5      = 8'h05;
    localparam logic [7:0] OFF_SCE      = 8'h06;

    // reset values
    localparam logic [7:0] RST_PDN      = 8'h00;
    localparam logic [7:0] RST_OVR      = 8'h00;
    localparam logic [7:0] RST_SPARE    = 8'h00;
    localparam logic [7:0] RST_SCE      = 8'h10;
    localparam logic [7:0] PDN_ALL_OFF  = 8'hff;

    // field positions
    localparam int STS_RESET_BIT        = 0;
    localparam int STS_GUARD_BIT        = 1;
    localparam int STS_DONE_BIT         = 2;
    localparam int STS_STRAP_LSB        = 3;
    localparam int STS_STRAP_MSB        = 6;
    localparam int OVR_PD_BIT           = 0;
    localparam int SCE_EN_BIT           = 3;

    // two-wire framing
    localparam logic [6:0] ADDR_BASE    = 7'h58;
    localparam logic [3:0] BYTE_BITS    = 4'h8;
    localparam logic [3:0] CNT_ZERO     = 4'h0;
    localparam logic [3:0] CNT_ONE      = 4'h1;
    localparam logic [7:0] OFF_STEP     = 8'h01;

    typedef enum logic [3:0] {
        SSC_IDLE  = 4'h0,
        SSC_ADDR  = 4'h1,
        SSC_ACK_A = 4'h3,
        SSC_OFFS  = 4'h2,
        SSC_ACK_O = 4'h6,
        SSC_WR    = 4'h7,
        SSC_ACK_W = 4'h5,
        SSC_RD    = 4'h4,
        SSC_MACK  = 4'hc
    } ssc_state_t;

    // pins that cross into the clock domain
    typedef struct packed {
        logic       scl;
        logic       sda;
        logic       pd_pin;
        logic [3:0] strap;
    } ssc_pins_t;

    localparam int PINS_W = $bits(ssc_pins_t);

    // synchroniser reset matches idle pin levels, so no false bus edge
    localparam ssc_pins_t PINS_IDLE = '{scl: 1'b1, sda: 1'b1, pd_pin: 1'b0, strap: 4'h0};

    typedef struct packed {
        ssc_state_t fsm;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic       rw;
        logic       nack;
        logic [7:0] offset;
        logic       scl_d;
        logic       sda_d;
        logic       sda_oe;
        logic       sda_out;
        logic [7:0] pdn;
        logic [7:0] ovr;
        logic [7:0] sp3;
        logic [7:0] sp4;
        logic [7:0] sp5;
        logic [7:0] sce;
        logic [7:0] pd_eff;
        logic       reg_en;
    } ssc_state_s_t;

endpackage
`default_nettype wire

/* File: src/ssc_regs.sv */
// two-wire slave with low control and status registers
// assumes open-drain bus resolved outside; loader done flag on same clock
//
// Summary of operation
// - status bits 6:3 show address straps
// - status bit 2 shows configuration load done
// - writing status bit 0 restores defaults, self-clears
// - guard bit 1 blocks that reset, self-clears
// - offset one holds eight channel power-downs
// - zeros enable all, ones disable all
// - channel bits act only under pin override
// - override set: register wins, else pin
// - offset six bit 3 enables register control
// - write: start, address, offset, data, acks
// - address byte B0 plus two per strap
`timescale 1ns/100ps
`default_nettype none
module ssc_regs (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       sys_rst,
    // two-wire bus pins
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output var  logic       sda_out,
    output var  logic       sda_oe,
    // straps and status from elsewhere
    input  wire logic [3:0] addr_strap,
    input  wire logic       power_down_pin,
    input  wire logic       eeprom_load_done,
    // controls to the channels
    output var  logic [7:0] channel_power_down_bits,
    output var  logic       slave_reg_enable
);

    ssc_pkg::ssc_state_s_t st_ff;
    ssc_pkg::ssc_state_s_t nxt_st;
    ssc_pkg::ssc_pins_t    pins_raw;
    ssc_pkg::ssc_pins_t    pins_s;
    logic                  scl_rise;
    logic                  scl_fall;
    logic                  bus_start;
    logic                  bus_stop;
    logic                  addr_hit;
    logic                  wr_evt;
    logic                  soft_rst;
    logic [7:0]            rdata;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    assign pins_raw = '{scl: scl_in, sda: sda_in, pd_pin: power_down_pin, strap: addr_strap};

    ssc_sync #(.W(ssc_pkg::PINS_W), .RST_VAL(ssc_pkg::PINS_IDLE)) u_sync (
        .clock   (clock),
        .sys_rst (sys_rst),
        .d       (pins_raw),
        .q       (pins_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // bus events and read mux

    assign scl_rise  = pins_s.scl & ~st_ff.scl_d;
    assign scl_fall  = ~pins_s.scl & st_ff.scl_d;
    assign bus_start = pins_s.scl & st_ff.scl_d & st_ff.sda_d & ~pins_s.sda;
    assign bus_stop  = pins_s.scl & st_ff.scl_d & ~st_ff.sda_d & pins_s.sda;
    assign addr_hit  = st_ff.shift[7:1] == 7'(ssc_pkg::ADDR_BASE + {3'h0, pins_s.strap});
    assign wr_evt    = (st_ff.fsm == ssc_pkg::SSC_WR) && scl_fall && (st_ff.cnt == ssc_pkg::BYTE_BITS);
    // guard in the same byte blocks the reset
    assign soft_rst  = wr_evt && (st_ff.offset == ssc_pkg::OFF_STATUS)
                     && st_ff.shift[ssc_pkg::STS_RESET_BIT]
                     && !st_ff.shift[ssc_pkg::STS_GUARD_BIT];

    always_comb begin
        rdata = 8'h00;
        unique case (st_ff.offset)
            ssc_pkg::OFF_STATUS: begin
                rdata[ssc_pkg::STS_STRAP_MSB:ssc_pkg::STS_STRAP_LSB] = pins_s.strap;
                rdata[ssc_pkg::STS_DONE_BIT] = eeprom_load_done;
                // reset and guard never stored, so read zero
                rdata[ssc_pkg::STS_GUARD_BIT] = 1'b0;
                rdata[ssc_pkg::STS_RESET_BIT] = 1'b0;
            end
            ssc_pkg::OFF_PDN: rdata = st_ff.pdn;
            ssc_pkg::OFF_OVR: rdata = st_ff.ovr;
            ssc_pkg::OFF_SP3: rdata = st_ff.sp3;
            ssc_pkg::OFF_SP4: rdata = st_ff.sp4;
            ssc_pkg::OFF_SP5: rdata = st_ff.sp5;
            ssc_pkg::OFF_SCE: rdata = st_ff.sce;
            default:          rdata = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // slave protocol and register writes

    always_comb begin
        nxt_st       = st_ff;
        nxt_st.scl_d = pins_s.scl;
        nxt_st.sda_d = pins_s.sda;
        if (scl_rise && st_ff.fsm != ssc_pkg::SSC_IDLE) begin
            nxt_st.cnt = 4'(st_ff.cnt + ssc_pkg::CNT_ONE);
            if (st_ff.fsm != ssc_pkg::SSC_RD) begin
                nxt_st.shift = {st_ff.shift[6:0], pins_s.sda};
            end
            if (st_ff.fsm == ssc_pkg::SSC_MACK) begin
                nxt_st.nack = pins_s.sda;
            end
        end
        if (bus_stop) begin
            nxt_st.fsm    = ssc_pkg::SSC_IDLE;
            nxt_st.sda_oe = 1'b0;
        end else if (bus_start) begin
            nxt_st.fsm    = ssc_pkg::SSC_ADDR;
            nxt_st.cnt    = ssc_pkg::CNT_ZERO;
            nxt_st.sda_oe = 1'b0;
        end else if (scl_fall) begin
            unique case (st_ff.fsm)
                ssc_pkg::SSC_IDLE: begin
                    nxt_st.sda_oe = 1'b0;
                end
                ssc_pkg::SSC_ADDR: begin
                    if (st_ff.cnt == ssc_pkg::BYTE_BITS) begin
                        if (addr_hit) begin
                            nxt_st.fsm    = ssc_pkg::SSC_ACK_A;
                            nxt_st.sda_oe = 1'b1;
                            nxt_st.rw     = st_ff.shift[0];
                        end else begin
                            nxt_st.fsm = ssc_pkg::SSC_IDLE;
                        end
                    end
                end
                ssc_pkg::SSC_ACK_A: begin
                    nxt_st.cnt = ssc_pkg::CNT_ZERO;
                    if (st_ff.rw) begin
                        nxt_st.fsm    = ssc_pkg::SSC_RD;
                        nxt_st.shift  = rdata;
                        nxt_st.sda_oe = ~rdata[7];
                    end else begin
                        nxt_st.fsm    = ssc_pkg::SSC_OFFS;
                        nxt_st.sda_oe = 1'b0;
                    end
                end
                ssc_pkg::SSC_OFFS: begin
                    if (st_ff.cnt == ssc_pkg::BYTE_BITS) begin
                        nxt_st.fsm    = ssc_pkg::SSC_ACK_O;
                        nxt_st.offset = st_ff.shift;
                        nxt_st.sda_oe = 1'b1;
                    end
                end
                ssc_pkg::SSC_ACK_O: begin
                    nxt_st.fsm    = ssc_pkg::SSC_WR;
                    nxt_st.cnt    = ssc_pkg::CNT_ZERO;
                    nxt_st.sda_oe = 1'b0;
                end
                ssc_pkg::SSC_WR: begin
                    if (st_ff.cnt == ssc_pkg::BYTE_BITS) begin
                        nxt_st.fsm    = ssc_pkg::SSC_ACK_W;
                        nxt_st.sda_oe = 1'b1;
                    end
                end
                ssc_pkg::SSC_ACK_W: begin
                    // further bytes land at following offsets
                    nxt_st.fsm    = ssc_pkg::SSC_WR;
                    nxt_st.cnt    = ssc_pkg::CNT_ZERO;
                    nxt_st.sda_oe = 1'b0;
                    nxt_st.offset = 8'(st_ff.offset + ssc_pkg::OFF_STEP);
                end
                ssc_pkg::SSC_RD: begin
                    if (st_ff.cnt == ssc_pkg::BYTE_BITS) begin
                        nxt_st.fsm    = ssc_pkg::SSC_MACK;
                        nxt_st.cnt    = ssc_pkg::CNT_ZERO;
                        nxt_st.sda_oe = 1'b0;
                        nxt_st.offset = 8'(st_ff.offset + ssc_pkg::OFF_STEP);
                    end else begin
                        nxt_st.shift  = {st_ff.shift[6:0], 1'b0};
                        nxt_st.sda_oe = ~st_ff.shift[6];
                    end
                end
                ssc_pkg::SSC_MACK: begin
                    nxt_st.cnt = ssc_pkg::CNT_ZERO;
                    if (st_ff.nack) begin
                        nxt_st.fsm = ssc_pkg::SSC_IDLE;
                    end else begin
                        nxt_st.fsm    = ssc_pkg::SSC_RD;
                        nxt_st.shift  = rdata;
                        nxt_st.sda_oe = ~rdata[7];
                    end
                end
                // illegal code recovers to idle
                default: begin
                    nxt_st.fsm    = ssc_pkg::SSC_IDLE;
                    nxt_st.sda_oe = 1'b0;
                end
            endcase
        end
        if (wr_evt) begin
            unique case (st_ff.offset)
                ssc_pkg::OFF_PDN: nxt_st.pdn = st_ff.shift;
                ssc_pkg::OFF_OVR: nxt_st.ovr = st_ff.shift;
                ssc_pkg::OFF_SP3: nxt_st.sp3 = st_ff.shift;
                ssc_pkg::OFF_SP4: nxt_st.sp4 = st_ff.shift;
                ssc_pkg::OFF_SP5: nxt_st.sp5 = st_ff.shift;
                ssc_pkg::OFF_SCE: nxt_st.sce = st_ff.shift;
                default: begin
                end
            endcase
        end
        if (soft_rst) begin
            nxt_st.pdn = ssc_pkg::RST_PDN;
            nxt_st.ovr = ssc_pkg::RST_OVR;
            nxt_st.sp3 = ssc_pkg::RST_SPARE;
            nxt_st.sp4 = ssc_pkg::RST_SPARE;
            nxt_st.sp5 = ssc_pkg::RST_SPARE;
            nxt_st.sce = ssc_pkg::RST_SCE;
        end
        // override picks register over pin
        nxt_st.pd_eff  = st_ff.ovr[ssc_pkg::OVR_PD_BIT] ? st_ff.pdn : {8{pins_s.pd_pin}};
        nxt_st.reg_en  = st_ff.sce[ssc_pkg::SCE_EN_BIT];
        nxt_st.sda_out = 1'b0;
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st_ff        <= '0;
            st_ff.fsm    <= ssc_pkg::SSC_IDLE;
            st_ff.scl_d  <= 1'b1;
            st_ff.sda_d  <= 1'b1;
            st_ff.pdn    <= ssc_pkg::RST_PDN;
            st_ff.ovr    <= ssc_pkg::RST_OVR;
            st_ff.sp3    <= ssc_pkg::RST_SPARE;
            st_ff.sp4    <= ssc_pkg::RST_SPARE;
            st_ff.sp5    <= ssc_pkg::RST_SPARE;
            st_ff.sce    <= ssc_pkg::RST_SCE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sda_out                 = st_ff.sda_out;
    assign sda_oe                  = st_ff.sda_oe;
    assign channel_power_down_bits = st_ff.pd_eff;
    assign slave_reg_enable        = st_ff.reg_en;

    ////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    sequence s_addr_match;
        (st_ff.fsm == ssc_pkg::SSC_ADDR) && scl_fall && (st_ff.cnt == ssc_pkg::BYTE_BITS) && addr_hit;
    endsequence

    sequence s_ack_drive;
        (st_ff.fsm == ssc_pkg::SSC_ACK_A) && sda_oe;
    endsequence

    property p_strap_view;
        (st_ff.offset == ssc_pkg::OFF_STATUS) |-> rdata[6:3] == pins_s.strap;
    endproperty
    a_strap_view: assert property (p_strap_view) else $error("strap view wrong");

    property p_done_view;
        (st_ff.offset == ssc_pkg::OFF_STATUS) |-> rdata[2] == eeprom_load_done;
    endproperty
    a_done_view: assert property (p_done_view) else $error("load done view wrong");

    property p_soft_reset;
        soft_rst |=> (st_ff.pdn == ssc_pkg::RST_PDN) && (st_ff.ovr == ssc_pkg::RST_OVR)
                     && (st_ff.sce == ssc_pkg::RST_SCE) && (st_ff.sp3 == ssc_pkg::RST_SPARE)
                     && (st_ff.sp4 == ssc_pkg::RST_SPARE) && (st_ff.sp5 == ssc_pkg::RST_SPARE);
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset missed");

    property p_guard;
        (wr_evt && st_ff.offset == ssc_pkg::OFF_STATUS && st_ff.shift[ssc_pkg::STS_GUARD_BIT])
            |=> $stable(st_ff.sce) && $stable(st_ff.pdn);
    endproperty
    a_guard: assert property (p_guard) else $error("guard did not block reset");

    property p_pdn_write;
        (wr_evt && st_ff.offset == ssc_pkg::OFF_PDN) |=> st_ff.pdn == $past(st_ff.shift);
    endproperty
    a_pdn_write: assert property (p_pdn_write) else $error("power-down write lost");

    property p_pd_reg;
        st_ff.ovr[ssc_pkg::OVR_PD_BIT] |=> channel_power_down_bits == $past(st_ff.pdn);
    endproperty
    a_pd_reg: assert property (p_pd_reg) else $error("register power-down not applied");

    property p_pd_pin;
        !st_ff.ovr[ssc_pkg::OVR_PD_BIT] |=> channel_power_down_bits == {8{$past(pins_s.pd_pin)}};
    endproperty
    a_pd_pin: assert property (p_pd_pin) else $error("pin power-down not applied");

    property p_reg_en;
        slave_reg_enable == $past(st_ff.sce[ssc_pkg::SCE_EN_BIT]);
    endproperty
    a_reg_en: assert property (p_reg_en) else $error("register enable wrong");

    property p_addr_ack;
        s_addr_match |=> s_ack_drive;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged");

    property p_data_ack;
        wr_evt |=> (st_ff.fsm == ssc_pkg::SSC_ACK_W) && sda_oe;
    endproperty
    a_data_ack: assert property (p_data_ack) else $error("data byte not acknowledged");

    property p_self_clear;
        (st_ff.offset == ssc_pkg::OFF_STATUS) |-> rdata[1:0] == 2'h0;
    endproperty
    a_self_clear: assert property (p_self_clear) else $error("self-clearing bits read set");

endmodule
`default_nettype wire

/* File: src/ssc_sync.sv */
// two-flop synchroniser, one stage pair per bit
// assumes inputs are asynchronous to clock
`timescale 1ns/100ps
`default_nettype none
module ssc_sync #(
    parameter int         W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         sys_rst,
    // data
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);

    logic [W-1:0] meta_ff;

    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clock or posedge sys_rst) begin
            if (sys_rst) begin
                meta_ff[i] <= RST_VAL[i];
                q[i]       <= RST_VAL[i];
            end else begin
                meta_ff[i] <= d[i];
                q[i]       <= meta_ff[i];
            end
        end
    end

endmodule
`default_nettype wire

/* File: tb/ssc_host.sv */
// host controller model driving the two-wire management bus
// assumes sda is resolved outside with a pull-up; scl is driven only here
`timescale 1ns/100ps
`default_nettype none
module ssc_host (
    // clock
    input  wire logic clock,
    // bus lines
    output var  logic scl,
    output var  logic sda_low,
    input  wire logic sda
);
    ////////////////////////////////////////////////////////////////////////
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // also serves as repeated start from scl low
    task automatic start_cond();
        sda_low = 1'b0;
        tick(4);
        scl = 1'b1;
        tick(4);
        sda_low = 1'b1;
        tick(4);
        scl = 1'b0;
    endtask

    task automatic stop_cond();
        sda_low = 1'b1;
        tick(4);
        scl = 1'b1;
        tick(4);
        sda_low = 1'b0;
        tick(4);
    endtask

    // sda changes only mid low phase
    task automatic bit_io(input logic b, output logic r);
        tick(4);
        sda_low = ~b;
        tick(4);
        scl = 1'b1;
        tick(4);
        r = sda;
        tick(4);
        scl = 1'b0;
    endtask

    task automatic byte_io(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(last, ack);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] off, input logic [7:0] dat,
                      output logic [2:0] acks);
        logic [7:0] rx;
        start_cond();
        byte_io(adr, 1'b1, rx, acks[2]);
        byte_io(off, 1'b1, rx, acks[1]);
        byte_io(dat, 1'b1, rx, acks[0]);
        stop_cond();
    endtask

    task automatic rd(input logic [7:0] adr, input logic [7:0] off, output logic [7:0] dat,
                      output logic [2:0] acks);
        logic [7:0] rx;
        logic       ign;
        start_cond();
        byte_io(adr, 1'b1, rx, acks[2]);
        byte_io(off, 1'b1, rx, acks[1]);
        start_cond();
        byte_io(adr | 8'h01, 1'b1, rx, acks[0]);
        byte_io(8'hff, 1'b1, dat, ign);
        stop_cond();
    endtask
endmodule
`default_nettype wire

/* File: tb/ssc_regs_test.sv */
// self-checking bench of the serial slave control registers
// assumes ssc_host as bus master; sda pulled up when released
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin \
    $display("unexpected %s expected %h seen %h", nm, e, g); failures++; end end
module ssc_regs_test;
    logic       clock;
    logic       sys_rst;
    logic       scl;
    logic       sda_low;
    wire  logic sda;
    logic       sda_out;
    logic       sda_oe;
    logic [3:0] addr_strap;
    logic       pd_pin;
    logic       done;
    logic [7:0] pdb;
    logic       sre;
    logic [15:0] rnd;
    logic [7:0] m_pdn;
    int         checks = 0;
    int         failures = 0;
    int         cycles = 0;

    assign sda = ~(sda_low | (sda_oe & ~sda_out));

    ssc_host host_u (.clock(clock), .scl(scl), .sda_low(sda_low), .sda(sda));

    ssc_regs dut_u (
        .clock(clock), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .addr_strap(addr_strap), .power_down_pin(pd_pin),
        .eeprom_load_done(done), .channel_power_down_bits(pdb), .slave_reg_enable(sre)
    );

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 80000) begin
            failures++;
            $display("timeout");
            results();
        end
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic logic [7:0] dev_adr();
        return 8'hb0 + {3'h0, addr_strap, 1'b0};
    endfunction

    function automatic logic [7:0] status();
        return {1'b0, addr_strap, done, 2'h0};
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic wreg(input logic [7:0] off, input logic [7:0] dat);
        logic [2:0] a;
        host_u.wr(dev_adr(), off, dat, a);
        `CHK("write acks", 3'h0, a)
    endtask

    task automatic rchk(input logic [7:0] off, input logic [7:0] exp);
        logic [7:0] d;
        logic [2:0] a;
        host_u.rd(dev_adr(), off, d, a);
        `CHK("read acks", 3'h0, a)
        `CHK("register read", exp, d)
    endtask

    task automatic end_test(input string nm);
        $display("test %s done", nm);
    endtask

    task automatic results();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] v;
        logic [2:0] a;
        sys_rst = 1'b1;
        addr_strap = 4'h0;
        pd_pin = 1'b0;
        done = 1'b0;
        rnd = 16'h6dae;
        m_pdn = 8'h00;
        tick(20);
        sys_rst = 1'b0;
        tick(8);
        // defaults, unmapped offset seven included
        for (int i = 0; i < 8; i++) begin
            rchk(i[7:0], (i == 0) ? status() : (i == 6) ? 8'h10 : 8'h00);
        end
        `CHK("reg enable", 1'b0, sre)
        `CHK("power down", 8'h00, pdb)
        end_test("defaults");
        for (int k = 0; k < 6; k++) begin
            rnd = lfsr(rnd);
            addr_strap = (k == 0) ? 4'hf : rnd[3:0];
            done = rnd[4];
            tick(6);
            rchk(8'h00, status());
            host_u.wr(dev_adr() ^ 8'h02, 8'h01, 8'h55, a);
            `CHK("foreign acks", 3'h7, a)
            rchk(8'h01, 8'h00);
        end
        end_test("straps");
        pd_pin = 1'b1;
        tick(6);
        `CHK("power down", 8'hff, pdb)
        for (int k = 0; k < 6; k++) begin
            rnd = lfsr(rnd);
            v = (k == 1) ? 8'hff : (k == 2) ? 8'h00 : rnd[7:0];
            if (k == 3)
                wreg(8'h02, 8'h01);
            wreg(8'h01, v);
            m_pdn = v;
            tick(4);
            `CHK("power down", (k > 2) ? v : {8{pd_pin}}, pdb)
            rchk(8'h01, v);
            pd_pin = ~pd_pin;
            tick(6);
            `CHK("pin ignored", (k > 2) ? v : {8{pd_pin}}, pdb)
        end
        end_test("power down");
        wreg(8'h06, 8'h18);
        `CHK("reg enable", 1'b1, sre)
        rchk(8'h06, 8'h18);
        wreg(8'h06, 8'h10);
        `CHK("reg enable", 1'b0, sre)
        wreg(8'h06, 8'h18);
        end_test("enable");
        wreg(8'h00, 8'h03);
        rchk(8'h01, m_pdn);
        rchk(8'h06, 8'h18);
        rchk(8'h00, status());
        `CHK("power down", m_pdn, pdb)
        wreg(8'h00, 8'h01);
        rchk(8'h00, status());
        rchk(8'h01, 8'h00);
        rchk(8'h02, 8'h00);
        rchk(8'h06, 8'h10);
        `CHK("reg enable", 1'b0, sre)
        `CHK("power down", {8{pd_pin}}, pdb)
        end_test("soft reset");
        results();
    end
endmodule
`undef CHK
`default_nettype wire
